// File: pkg/adcfr_defines.vh
// Constants for the conversion and filter reset controller
`ifndef ADCFR_DEFINES_VH
`define ADCFR_DEFINES_VH
// Register addresses of the four front configuration registers
`define ADCFR_ADDR_INSEL 4'h0
`define ADCFR_ADDR_BIAS 4'h1
`define ADCFR_ADDR_REFCTL 4'h2
`define ADCFR_ADDR_GAINRATE 4'h3
`define ADCFR_ADDR_LAST_FRONT 4'h4
// Command bytes (arbitrary encoding)
`define ADCFR_CMD_WAKE 8'h00
`define ADCFR_CMD_SLEEP 8'h02
`define ADCFR_CMD_RESYNC 8'h04
`define ADCFR_CMD_WRITE_HI 4'h4
// Resync delay in system clocks after seventh serial clock fall
`define ADCFR_RESYNC_DELAY 3'h4
`define ADCFR_RESYNC_BIT 4'h7
// Filter hold after slow register write, modulator clocks
`define ADCFR_HOLD_MOD_CLKS 32
`define ADCFR_MOD_DIV 4
// Data rate codes
`define ADCFR_RATE_W 4
`endif

// File: design/adcfr_rate_table.v
// Conversion length lookup per data rate and start kind
`timescale 1ns/1ps
`default_nettype none
module adcfr_rate_table
(
  input wire clk,
  input wire ce,
  input wire [3:0] rate,
  input wire [1:0] kind,
  output reg [19:0] count_q
);
  // ************************************************************
  // Registered lookup: kind 0 fast first, 1 slow first, 2 later
  // ************************************************************
  always @(posedge clk)
  begin
    if (ce)
    begin
      case ({kind, rate})
        6'h00: count_q <= 20'd816160;
        6'h01: count_q <= 20'd408096;
        6'h02: count_q <= 20'd204064;
        6'h03: count_q <= 20'd102072;
        6'h04: count_q <= 20'd51064;
        6'h05: count_q <= 20'd25560;
        6'h06: count_q <= 20'd12796;
        6'h07: count_q <= 20'd6428;
        6'h08: count_q <= 20'd4156;
        6'h10: count_q <= 20'd820265;
        6'h11: count_q <= 20'd412201;
        6'h12: count_q <= 20'd208169;
        6'h13: count_q <= 20'd103106;
        6'h14: count_q <= 20'd52098;
        6'h15: count_q <= 20'd26594;
        6'h16: count_q <= 20'd13314;
        6'h17: count_q <= 20'd6946;
        6'h18: count_q <= 20'd4674;
        6'h19: count_q <= 20'd2370;
        6'h20: count_q <= 20'd816128;
        6'h21: count_q <= 20'd408064;
        6'h22: count_q <= 20'd204032;
        6'h23: count_q <= 20'd102016;
        6'h24: count_q <= 20'd51008;
        6'h25: count_q <= 20'd25504;
        6'h26: count_q <= 20'd12736;
        6'h27: count_q <= 20'd6368;
        6'h28: count_q <= 20'd4096;
        6'h29: count_q <= 20'd2048;
        default: count_q <= 20'd2108;
      endcase
    end
  end
endmodule
`default_nettype wire

// File: design/adcfr_sync2.v
// Two-stage synchroniser for outside signals
`timescale 1ns/1ps
`default_nettype none
module adcfr_sync2 #(
  parameter W = 3
)
(
  input wire clk,
  input wire ce,
  input wire [W-1:0] d,
  output reg [W-1:0] q
);
  reg [W-1:0] meta_q;
  // ************************************************************
  // Two flip-flops, first read only by second
  // ************************************************************
  always @(posedge clk)
  begin
    if (ce)
    begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule
`default_nettype wire

// File: design/adcfr_ctrl.v
// Conversion sequencing and digital filter reset control
`timescale 1ns/1ps
`default_nettype none
`include "adcfr_defines.vh"
module adcfr_ctrl
(
  input wire REF_CLK,
  input wire RESET_N,
  input wire CLK_EN,
  input wire START,
  input wire SCLK,
  input wire CS_N,
  input wire DIN,
  output reg DATA_READY_N,
  output reg FILTER_RESET_N,
  output reg POWERED,
  output reg CONVERTING,
  output reg [7:0] INPUT_SELECT,
  output reg [7:0] BIAS_ENABLE,
  output reg [7:0] REF_AND_CONTROL,
  output reg [7:0] GAIN_AND_RATE
);
  // ************************************************************
  // Pin synchronisation
  // ************************************************************
  wire [2:0] pins_s;
  adcfr_sync2 #(.W(3)) u_sync
  (
    .clk(REF_CLK),
    .ce(CLK_EN),
    .d({START, SCLK, CS_N}),
    .q(pins_s)
  );
  wire start_s = pins_s[2];
  wire sclk_s = pins_s[1];
  wire cs_n_s = pins_s[0];
  reg start_d1_q;
  reg sclk_d1_q;
  reg din_m_q;
  reg din_q;
  wire sclk_rise = sclk_s & ~sclk_d1_q;
  wire sclk_fall = ~sclk_s & sclk_d1_q;
  wire start_rise = start_s & ~start_d1_q;
  wire start_fall = ~start_s & start_d1_q;

  // ************************************************************
  // Serial receiver: byte shifter and command decode
  // ************************************************************
  reg [7:0] shift_q;
  reg [3:0] bitcnt_q;
  reg [1:0] phase_q;
  reg [3:0] addr_q;
  reg [3:0] left_q;
  reg resync_arm_q;
  reg [2:0] resync_dly_q;
  reg byte_done_q;
  wire [7:0] byte_now = {shift_q[6:0], din_q};
  localparam PH_CMD = 2'd0;
  localparam PH_CNT = 2'd1;
  localparam PH_DATA = 2'd2;
  localparam PH_IGN = 2'd3;
  // Resync byte; its top seven bits are known at the seventh clock
  localparam [7:0] CMD_RESYNC = `ADCFR_CMD_RESYNC;

  // Decodes whether an address is a front configuration register
  function is_front;
    input [3:0] a;
    begin
      is_front = (a < `ADCFR_ADDR_LAST_FRONT);
    end
  endfunction

  // Event pulses produced by the receiver
  reg ev_sleep;
  reg ev_wake;
  reg ev_insel_wr;
  reg ev_slow_wr;
  reg ev_resync;

  // ************************************************************
  // Receiver process
  // ************************************************************
  always @(posedge REF_CLK)
  begin
    if (!RESET_N)
    begin
      shift_q <= 8'h00;
      bitcnt_q <= 4'h0;
      phase_q <= PH_CMD;
      addr_q <= 4'h0;
      left_q <= 4'h0;
      resync_arm_q <= 1'b0;
      resync_dly_q <= 3'h0;
      byte_done_q <= 1'b0;
      ev_sleep <= 1'b0;
      ev_wake <= 1'b0;
      ev_insel_wr <= 1'b0;
      ev_slow_wr <= 1'b0;
      ev_resync <= 1'b0;
      INPUT_SELECT <= 8'h01;
      BIAS_ENABLE <= 8'h00;
      REF_AND_CONTROL <= 8'h00;
      GAIN_AND_RATE <= 8'h00;
      start_d1_q <= 1'b0;
      sclk_d1_q <= 1'b0;
      din_m_q <= 1'b0;
      din_q <= 1'b0;
    end
    else if (CLK_EN)
    begin
      start_d1_q <= start_s;
      sclk_d1_q <= sclk_s;
      din_m_q <= DIN;
      din_q <= din_m_q;
      ev_sleep <= 1'b0;
      ev_wake <= 1'b0;
      ev_insel_wr <= 1'b0;
      ev_slow_wr <= 1'b0;
      ev_resync <= 1'b0;
      byte_done_q <= 1'b0;
      // Resync fires four system clocks after the seventh serial clock fall
      if (resync_dly_q != 3'h0)
      begin
        resync_dly_q <= resync_dly_q - 3'h1;
        if (resync_dly_q == 3'h1)
          ev_resync <= 1'b1;
      end
      if (cs_n_s)
      begin
        bitcnt_q <= 4'h0;
        phase_q <= PH_CMD;
        resync_arm_q <= 1'b0;
      end
      else
      begin
        if (sclk_rise)
        begin
          shift_q <= byte_now;
          bitcnt_q <= (bitcnt_q == 4'h7) ? 4'h0 : bitcnt_q + 4'h1;
          if (phase_q == PH_CMD && bitcnt_q == 4'h6)
            resync_arm_q <= (byte_now[6:0] == CMD_RESYNC[7:1]);
          if (bitcnt_q == 4'h7)
          begin
            byte_done_q <= 1'b1;
            case (phase_q)
              PH_CMD:
              begin
                if (byte_now == `ADCFR_CMD_SLEEP)
                  ev_sleep <= 1'b1;
                else if (byte_now == `ADCFR_CMD_WAKE)
                  ev_wake <= 1'b1;
                else if (byte_now[7:4] == `ADCFR_CMD_WRITE_HI)
                begin
                  addr_q <= byte_now[3:0];
                  phase_q <= PH_CNT;
                end
              end
              PH_CNT:
              begin
                left_q <= byte_now[3:0];
                phase_q <= PH_DATA;
              end
              PH_DATA:
              begin
                // Each byte takes effect as soon as it lands
                case (addr_q)
                  `ADCFR_ADDR_INSEL: INPUT_SELECT <= byte_now;
                  `ADCFR_ADDR_BIAS: BIAS_ENABLE <= byte_now;
                  `ADCFR_ADDR_REFCTL: REF_AND_CONTROL <= byte_now;
                  `ADCFR_ADDR_GAINRATE: GAIN_AND_RATE <= byte_now;
                  default: ;
                endcase
                if (addr_q == `ADCFR_ADDR_INSEL)
                  ev_insel_wr <= 1'b1;
                else if (is_front(addr_q))
                  ev_slow_wr <= 1'b1;
                addr_q <= addr_q + 4'h1;
                left_q <= left_q - 4'h1;
                if (left_q == 4'h0)
                  phase_q <= PH_IGN;
              end
              default: ;
            endcase
          end
        end
        // Seventh serial clock falling edge of resync command
        if (sclk_fall && resync_arm_q && phase_q == PH_CMD &&
            bitcnt_q == `ADCFR_RESYNC_BIT)
        begin
          resync_arm_q <= 1'b0;
          resync_dly_q <= `ADCFR_RESYNC_DELAY;
        end
      end
    end
  end

  // ************************************************************
  // Filter reset pulses, ANDed
  // ************************************************************
  localparam HOLD_W = 8;
  localparam integer HOLD_PROD = `ADCFR_HOLD_MOD_CLKS * `ADCFR_MOD_DIV;
  localparam [HOLD_W-1:0] HOLD_CLKS = HOLD_PROD[HOLD_W-1:0];
  reg [HOLD_W-1:0] slow_hold_q;
  reg [HOLD_W-1:0] start_hold_q;
  wire slow_rst_n = (slow_hold_q == {HOLD_W{1'b0}});
  wire start_rst_n = (start_hold_q == {HOLD_W{1'b0}});
  wire fast_rst_n = ~(ev_resync | ev_insel_wr);
  wire filt_rst_n = slow_rst_n & start_rst_n & fast_rst_n;

  // ************************************************************
  // Conversion state
  // ************************************************************
  reg run_q;
  reg pulse_mode_q;
  reg [1:0] kind_q;
  reg [1:0] kind_d;
  reg load_q;
  reg [19:0] cnt_q;
  reg [1:0] ready_left_q;
  wire [19:0] table_count;
  wire [3:0] rate = GAIN_AND_RATE[3:0];
  // Any event that abandons the conversion and starts a new one
  wire restart = start_rise | ev_wake | ev_resync | ev_insel_wr | ev_slow_wr;

  adcfr_rate_table u_table
  (
    .clk(REF_CLK),
    .ce(CLK_EN),
    .rate(rate),
    .kind(kind_d),
    .count_q(table_count)
  );

  // Next length kind, held until the lookup is consumed
  always @*
  begin
    kind_d = kind_q;
    if (ev_resync || ev_insel_wr)
      kind_d = 2'd0;
    else if (start_rise || ev_wake || ev_slow_wr)
      kind_d = 2'd1;
  end

  // ************************************************************
  // Sequencer: restart on filter reset, count, signal completion
  // ************************************************************
  always @(posedge REF_CLK)
  begin
    if (!RESET_N)
    begin
      run_q <= 1'b0;
      pulse_mode_q <= 1'b0;
      kind_q <= 2'd1;
      load_q <= 1'b0;
      cnt_q <= 20'h00000;
      ready_left_q <= 2'd0;
      slow_hold_q <= {HOLD_W{1'b0}};
      start_hold_q <= {HOLD_W{1'b0}};
      DATA_READY_N <= 1'b1;
      FILTER_RESET_N <= 1'b1;
      POWERED <= 1'b0;
      CONVERTING <= 1'b0;
    end
    else if (CLK_EN)
    begin
      FILTER_RESET_N <= filt_rst_n;
      kind_q <= kind_d;
      load_q <= 1'b0;
      if (slow_hold_q != {HOLD_W{1'b0}})
        slow_hold_q <= slow_hold_q - {{(HOLD_W-1){1'b0}}, 1'b1};
      if (start_hold_q != {HOLD_W{1'b0}})
        start_hold_q <= start_hold_q - {{(HOLD_W-1){1'b0}}, 1'b1};
      if (ev_slow_wr)
        slow_hold_q <= HOLD_CLKS;
      if (start_rise)
      begin
        start_hold_q <= HOLD_CLKS;
        run_q <= 1'b1;
        pulse_mode_q <= 1'b0;
        load_q <= 1'b1;
        DATA_READY_N <= 1'b1;
      end
      else if (start_fall)
        pulse_mode_q <= 1'b1;
      else if (ev_sleep)
        pulse_mode_q <= 1'b1;
      if (ev_wake || ev_resync || ev_insel_wr || ev_slow_wr)
      begin
        // Abandon current conversion, no result produced
        run_q <= 1'b1;
        load_q <= 1'b1;
        DATA_READY_N <= 1'b1;
        if (ev_wake)
          pulse_mode_q <= 1'b0;
      end
      POWERED <= run_q;
      CONVERTING <= run_q & filt_rst_n;
      // Data ready stands four clocks, also once powered down
      if (!DATA_READY_N)
      begin
        if (ready_left_q == 2'd0)
          DATA_READY_N <= 1'b1;
        else
          ready_left_q <= ready_left_q - 2'd1;
      end
      // Count from the restart, filter settling time included
      if (load_q)
        cnt_q <= 20'h00000;
      else if (run_q && !restart)
      begin
        if (cnt_q == table_count - 20'h1)
        begin
          cnt_q <= 20'h00000;
          DATA_READY_N <= 1'b0;
          ready_left_q <= 2'd3;
          kind_q <= 2'd2;
          // First result is final: no discard cycles
          if (pulse_mode_q)
            run_q <= 1'b0;
        end
        else
          cnt_q <= cnt_q + 20'h1;
      end
    end
  end
endmodule
`default_nettype wire

// File: test/adcfr_properties.sv
// Concurrent checks on the conversion and filter reset controller
`timescale 1ns/1ps
`default_nettype none
module adcfr_properties
(
  input wire REF_CLK,
  input wire RESET_N,
  input wire CLK_EN,
  input wire START,
  input wire SCLK,
  input wire CS_N,
  input wire DIN,
  input wire DATA_READY_N,
  input wire FILTER_RESET_N,
  input wire POWERED,
  input wire CONVERTING,
  input wire [7:0] INPUT_SELECT,
  input wire [7:0] BIAS_ENABLE,
  input wire [7:0] REF_AND_CONTROL,
  input wire [7:0] GAIN_AND_RATE
);
  logic [11:0] low_q;
  logic [11:0] idle_q;
  // ******
  // Checks
  // ******
  // Filter reset run length, cycles since data ready
  always @(posedge REF_CLK)
  begin
    if (!RESET_N)
    begin
      low_q <= 12'h000;
      idle_q <= 12'h000;
    end
    else
    begin
      low_q <= FILTER_RESET_N ? 12'h000 : low_q + {11'h000, ~&low_q};
      idle_q <= !DATA_READY_N ? 12'h000 : idle_q + {11'h000, ~&idle_q};
    end
  end
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (!RESET_N);
  a_ready_release: assert property
    ($fell(DATA_READY_N) |-> ##[1:5] DATA_READY_N)
    else $error("data ready held low too long");
  a_idle_in_reset: assert property
    (!FILTER_RESET_N [*2] |-> !CONVERTING)
    else $error("converting while filter held in reset");
  a_done_after_run: assert property
    ($fell(DATA_READY_N) |-> $past(CONVERTING))
    else $error("data ready without a running conversion");
  a_start_rise_reset: assert property
    ($rose(START) |-> ##[2:6] !FILTER_RESET_N)
    else $error("start rise gave no filter reset");
  a_pulse_length: assert property
    ($rose(FILTER_RESET_N) |-> low_q == 12'h001 || low_q >= 12'h080)
    else $error("filter reset pulse has a wrong length");
  a_slow_write_reset: assert property
    ($changed(BIAS_ENABLE) || $changed(REF_AND_CONTROL) ||
      $changed(GAIN_AND_RATE) |-> ##[0:4] !FILTER_RESET_N)
    else $error("setting change without filter reset");
  a_insel_reset: assert property
    ($changed(INPUT_SELECT) |-> ##[0:4] !FILTER_RESET_N)
    else $error("input select change without filter reset");
  a_conv_spacing: assert property
    ($fell(DATA_READY_N) |-> idle_q >= 12'h7d0)
    else $error("results closer than the fastest conversion");
  a_run_needs_power: assert property
    (CONVERTING |-> POWERED || $past(POWERED))
    else $error("converting while powered down");
endmodule
bind adcfr_ctrl adcfr_properties adcfr_properties_i
(
  .REF_CLK(REF_CLK), .RESET_N(RESET_N), .CLK_EN(CLK_EN), .START(START),
  .SCLK(SCLK), .CS_N(CS_N), .DIN(DIN), .DATA_READY_N(DATA_READY_N),
  .FILTER_RESET_N(FILTER_RESET_N), .POWERED(POWERED),
  .CONVERTING(CONVERTING), .INPUT_SELECT(INPUT_SELECT),
  .BIAS_ENABLE(BIAS_ENABLE), .REF_AND_CONTROL(REF_AND_CONTROL),
  .GAIN_AND_RATE(GAIN_AND_RATE)
);
`default_nettype wire

// File: test/adcfr_host.sv
// Host model driving the serial command port
`timescale 1ns/1ps
`default_nettype none
module adcfr_host
(
  input wire logic clk,
  output logic SCLK,
  output logic CS_N,
  output logic DIN
);
  // Idle lines: clock still, select high
  initial
  begin
    SCLK = 1'b0;
    CS_N = 1'b1;
    DIN = 1'b1;
  end
  // Half of a 400 ns serial clock period
  task automatic half();
    repeat (4) @(negedge clk);
  endtask
  // One byte MSB first, data set while clock low
  task automatic send_byte(input logic [7:0] b);
    int i;
    for (i = 7; i >= 0; i--)
    begin
      DIN = b[i];
      half();
      SCLK = 1'b1;
      half();
      SCLK = 1'b0;
    end
  endtask
  task automatic open_frame();
    CS_N = 1'b0;
    half();
  endtask
  // Released data line shows the inverse of its last bit
  task automatic close_frame();
    half();
    CS_N = 1'b1;
    DIN = ~DIN;
  endtask
endmodule
`default_nettype wire

// File: test/tb.sv
// Self-checking bench for the conversion and filter reset controller
`timescale 1ns/1ps
`default_nettype none
`include "adcfr_defines.vh"
module tb;
  logic REF_CLK = 1'b0;
  logic RESET_N = 1'b0;
  logic START = 1'b0;
  logic CLK_EN = 1'b1;
  logic fr_prev = 1'b1;
  wire SCLK, CS_N, DIN, DATA_READY_N, FILTER_RESET_N, POWERED, CONVERTING;
  wire [7:0] INPUT_SELECT, BIAS_ENABLE, REF_AND_CONTROL, GAIN_AND_RATE;
  int n_fail = 0;
  int n_compared = 0;
  int cyc = 0;
  int rst_at = 0;
  int done_at = 0;
  int since = 0;
  int gap = 0;
  int mark = 0;
  // ******
  // Set-up
  // ******
  always #25 REF_CLK = ~REF_CLK;
  adcfr_ctrl adcfr_ctrl_i
  (
    .REF_CLK(REF_CLK), .RESET_N(RESET_N), .CLK_EN(CLK_EN), .START(START),
    .SCLK(SCLK), .CS_N(CS_N), .DIN(DIN), .DATA_READY_N(DATA_READY_N),
    .FILTER_RESET_N(FILTER_RESET_N), .POWERED(POWERED),
    .CONVERTING(CONVERTING), .INPUT_SELECT(INPUT_SELECT),
    .BIAS_ENABLE(BIAS_ENABLE), .REF_AND_CONTROL(REF_AND_CONTROL),
    .GAIN_AND_RATE(GAIN_AND_RATE)
  );
  adcfr_host adcfr_host_i (.clk(REF_CLK), .SCLK(SCLK), .CS_N(CS_N), .DIN(DIN));
  // Cycle count, filter reset start, hang guard
  always @(posedge REF_CLK)
  begin
    cyc <= cyc + 1;
    fr_prev <= FILTER_RESET_N;
    if (fr_prev === 1'b1 && FILTER_RESET_N === 1'b0)
      rst_at <= cyc;
    if (cyc == 40000)
    begin
      n_fail++;
      close_out();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic in_range(input int v, input int lo, input int hi);
    check({31'h0, (v >= lo && v <= hi)}, 32'h1);
  endtask
  // Await a result, note cycles since filter reset and last result
  task automatic wait_done();
    int k;
    for (k = 0; k < 3000 && DATA_READY_N !== 1'b0; k++)
      @(negedge REF_CLK);
    check({31'h0, DATA_READY_N}, 32'h0);
    since = cyc - rst_at;
    gap = cyc - done_at;
    done_at = cyc;
    repeat (6) @(negedge REF_CLK);
  endtask
  task automatic cmd(input logic [7:0] b);
    adcfr_host_i.open_frame();
    adcfr_host_i.send_byte(b);
    adcfr_host_i.close_frame();
    repeat (4) @(negedge REF_CLK);
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    adcfr_host_i.open_frame();
    adcfr_host_i.send_byte({`ADCFR_CMD_WRITE_HI, a});
    adcfr_host_i.send_byte(8'h00);
    adcfr_host_i.send_byte(d);
    adcfr_host_i.close_frame();
    repeat (64) @(negedge REF_CLK);
  endtask
  task automatic close_out();
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // *********
  // Sequence
  // *********
  initial
  begin
    repeat (10) @(negedge REF_CLK);
    RESET_N = 1'b1;
    repeat (4) @(negedge REF_CLK);
    check(INPUT_SELECT, 32'h01);
    check({GAIN_AND_RATE, BIAS_ENABLE, REF_AND_CONTROL, DATA_READY_N,
      FILTER_RESET_N, POWERED}, 32'h6);
    START = 1'b1;
    repeat (8) @(negedge REF_CLK);
    check({FILTER_RESET_N, POWERED}, 32'h1);
    wr(`ADCFR_ADDR_GAINRATE, 8'h09);
    check(GAIN_AND_RATE, 32'h09);
    wait_done();
    in_range(since, 2366, 2374);
    wait_done();
    in_range(gap, 2047, 2049);
    // Clock enable low freezes the conversion count
    CLK_EN = 1'b0;
    repeat (300) @(negedge REF_CLK);
    CLK_EN = 1'b1;
    wait_done();
    in_range(gap, 2347, 2349);
    wr(`ADCFR_ADDR_REFCTL, 8'h30);
    check(REF_AND_CONTROL, 32'h30);
    // Two bytes in one write, each applied on arrival
    adcfr_host_i.open_frame();
    adcfr_host_i.send_byte({`ADCFR_CMD_WRITE_HI, `ADCFR_ADDR_INSEL});
    adcfr_host_i.send_byte(8'h01);
    adcfr_host_i.send_byte(8'h23);
    repeat (6) @(negedge REF_CLK);
    check({INPUT_SELECT, BIAS_ENABLE}, 32'h2300);
    adcfr_host_i.send_byte(8'h05);
    adcfr_host_i.close_frame();
    check(BIAS_ENABLE, 32'h05);
    repeat (64) @(negedge REF_CLK);
    mark = cyc;
    wr(`ADCFR_ADDR_INSEL, 8'h23);
    in_range(rst_at, mark, cyc);
    wait_done();
    in_range(since, 2105, 2112);
    repeat (500) @(negedge REF_CLK);
    mark = cyc;
    cmd(`ADCFR_CMD_RESYNC);
    in_range(rst_at - mark, 63, 71);
    wait_done();
    in_range(since, 2105, 2112);
    in_range(gap, 2600, 9999);
    cmd(`ADCFR_CMD_SLEEP);
    wait_done();
    check(POWERED, 32'h0);
    repeat (2200) @(negedge REF_CLK);
    check({DATA_READY_N, POWERED}, 32'h2);
    mark = cyc;
    cmd(`ADCFR_CMD_WAKE);
    check(POWERED, 32'h1);
    wait_done();
    in_range(cyc - mark, 2420, 2470);
    START = 1'b0;
    wait_done();
    check({CONVERTING, POWERED}, 32'h0);
    START = 1'b1;
    wait_done();
    in_range(since, 2366, 2374);
    wr(4'h5, 8'hff);
    check({INPUT_SELECT, GAIN_AND_RATE}, 32'h2309);
    close_out();
  end
endmodule
`default_nettype wire
